// ==== core/clock_select_defines.svh ====
`ifndef CLOCK_SELECT_DEFINES_SVH
`define CLOCK_SELECT_DEFINES_SVH
// Register indices; byte address is four times the index
`define CSEL_IDX 8'h8F
`define ICTL_IDX 8'hA1
`define CRS_IDX 8'hA2
`define FIN_IDX 8'h9E
`define XCTL_IDX 8'hB1
`define MCTL_IDX 8'hB2
// Field positions
`define ICTL_EN_HI 7
`define ICTL_EN_LO 6
`define ICTL_SUSP_BIT 5
`define XCTL_EN_BIT 0
`define MCTL_SRC_BIT 0
`define MCTL_X4_BIT 1
`define MCTL_DIV_HI 6
`define MCTL_DIV_LO 4
// Reset values
`define IDIV_RST 3'h0
`define IEN_RST 2'h3
`define IEN_RUN 2'h3
`define MDIV_RST 3'h2
`define CRS_CAL 7'h40
`define FIN_CAL 6'h20
// Timing: external oscillator edges before the crystal counts as settled
`define XTAL_SETTLE_TICKS 16'h0400
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== core/clock_select_pkg.sv ====
package clock_select_pkg;
  typedef enum logic [1:0] {
    SRC_INT  = 2'h0,
    SRC_EXT  = 2'h1,
    SRC_MULT = 2'h2,
    SRC_RSVD = 2'h3
  } src_e;
  typedef enum logic [2:0] {
    OSC_OFF  = 3'h1,
    OSC_RUN  = 3'h2,
    OSC_SUSP = 3'h4
  } osc_e;
endpackage : clock_select_pkg

// ==== core/clk_tick_if.sv ====
`timescale 1ns/1ps
interface clk_tick_if;
  logic                      int_tick;
  logic                      ext_tick;
  clock_select_pkg::src_e    src;
  logic [2:0]                div_sel;
  logic                      mult_ext;
  logic                      mult_x4;
  logic [2:0]                mult_div;
  logic                      sys_tick;
  modport gen (input int_tick, ext_tick, src, div_sel, mult_ext, mult_x4, mult_div,
               output sys_tick);
  modport ctl (output int_tick, ext_tick, src, div_sel, mult_ext, mult_x4, mult_div,
               input sys_tick);
endinterface : clk_tick_if

// ==== core/clock_tick_gen.sv ====
`timescale 1ns/1ps
`include "clock_select_defines.svh"
module clock_tick_gen (
  input wire logic clk_in,
  input wire logic rst_n_in,
  clk_tick_if.gen  t
);
  logic [6:0]             div_cnt_reg;
  logic [6:0]             div_last;
  logic                   int_div_tick;
  logic [4:0]             acc_reg;
  logic [2:0]             mul_n;
  logic [4:0]             mul_add;
  logic                   mul_src;
  logic                   mult_tick;
  clock_select_pkg::src_e act_reg;

  // Divide by 128 >> select: code 0 is /128, code 7 is /1
  assign div_last = 7'((8'h80 >> t.div_sel) - 8'h01);
  assign int_div_tick = t.int_tick && (div_cnt_reg >= div_last);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      div_cnt_reg <= 7'h00;
    end else if (int_div_tick) begin
      div_cnt_reg <= 7'h00;
    end else if (t.int_tick) begin
      div_cnt_reg <= div_cnt_reg + 7'h01;
    end
  end

  // Rate = source x 2 or x 4, times 2/N; N below 2 counts as 2 (factor 1)
  assign mul_n = (t.mult_div < 3'h2) ? 3'h2 : t.mult_div;
  assign mul_src = t.mult_ext ? t.ext_tick : t.int_tick;
  assign mul_add = mul_src ? (t.mult_x4 ? 5'h08 : 5'h04) : 5'h00;
  assign mult_tick = (acc_reg >= {2'h0, mul_n});

  // Limitation: one output tick per cycle, so source ticks must be spaced
  // widely enough for the chosen ratio or the 5-bit credit overflows and wraps
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      acc_reg <= 5'h00;
    end else begin
      acc_reg <= acc_reg + mul_add - (mult_tick ? {2'h0, mul_n} : 5'h00);
    end
  end

  function automatic logic tick_of(input clock_select_pkg::src_e s);
    case (s)
      clock_select_pkg::SRC_INT:  tick_of = int_div_tick;
      clock_select_pkg::SRC_EXT:  tick_of = t.ext_tick;
      clock_select_pkg::SRC_MULT: tick_of = mult_tick;
      default:                    tick_of = 1'b0;
    endcase
  endfunction : tick_of

  // Switch only in a cycle where neither source ticks: no runt pulse
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      act_reg <= clock_select_pkg::SRC_INT;
    end else if (t.src != clock_select_pkg::SRC_RSVD && t.src != act_reg &&
                 !tick_of(act_reg) && !tick_of(t.src)) begin
      act_reg <= t.src;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      t.sys_tick <= 1'b0;
    end else begin
      t.sys_tick <= tick_of(act_reg);
    end
  end
endmodule : clock_tick_gen

// ==== core/clock_select_top.sv ====
// What this block does
// - Two-bit field picks internal, external or multiplier
// - Clock select upper six bits read zero
// - Reset runs system clock from internal oscillator
// - Source may switch live; software picks settled sources
// - External oscillator still ticks timers, counter array
// - Internal oscillator usable right after enabling write
// - Hardware sets crystal valid once settled
// - Internal divider 1 to 128, 128 after reset
// - Multiplier gives x2 or x4 scaled 2/N
// - Trim values default to factory calibration
// - Suspend halts oscillator and stops dependent core
// - Port match or comparator low wakes suspend
// - Wake restarts oscillator and core regardless of interrupt
// - Core resumes at instruction after suspend write
// - Divider code 000 is /128, 111 is /1
// - Enable 11 runs oscillator, 00 disables it
// - Frequency ready sets on a tick while running, clears the cycle after it stops
`timescale 1ns/1ps
`include "clock_select_defines.svh"
module clock_select_top (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        INT_OSC_TICK_IN,
  input  wire logic        EXT_OSC_TICK_IN,
  input  wire logic [3:0]  PORT_MATCH_IN,
  input  wire logic        CMP0_EN_IN,
  input  wire logic        CMP0_OUT_IN,
  input  wire logic [9:0]  AXI_AWADDR_IN,
  input  wire logic        AXI_AWVALID_IN,
  output logic             AXI_AWREADY_OUT,
  input  wire logic [31:0] AXI_WDATA_IN,
  input  wire logic [3:0]  AXI_WSTRB_IN,
  input  wire logic        AXI_WVALID_IN,
  output logic             AXI_WREADY_OUT,
  output logic [1:0]       AXI_BRESP_OUT,
  output logic             AXI_BVALID_OUT,
  input  wire logic        AXI_BREADY_IN,
  input  wire logic [9:0]  AXI_ARADDR_IN,
  input  wire logic        AXI_ARVALID_IN,
  output logic             AXI_ARREADY_OUT,
  output logic [31:0]      AXI_RDATA_OUT,
  output logic [1:0]       AXI_RRESP_OUT,
  output logic             AXI_RVALID_OUT,
  input  wire logic        AXI_RREADY_IN,
  output logic             SYS_TICK_OUT,
  output logic             TIMER_EXT_TICK_OUT,
  output logic             CORE_STALL_OUT,
  output logic             INT_OSC_RUN_OUT,
  output logic             EXT_OSC_EN_OUT,
  output logic [6:0]       COARSE_TRIM_OUT,
  output logic [5:0]       FINE_TRIM_OUT
);
  clk_tick_if tk ();

  logic                   aw_got_reg;
  logic                   w_got_reg;
  logic [7:0]             aw_idx_reg;
  logic [7:0]             wdata_reg;
  logic                   wstrb0_reg;
  logic                   wr_fire;
  logic                   wr_ok;
  logic [31:0]            rd_word;
  logic                   rd_ok;
  logic [7:0]             ar_idx;
  clock_select_pkg::src_e sel_reg;
  logic [1:0]             osc_en_reg;
  logic [2:0]             div_reg;
  logic [6:0]             crs_reg;
  logic [5:0]             fin_reg;
  logic                   ext_en_reg;
  logic                   mult_ext_reg;
  logic                   mult_x4_reg;
  logic [2:0]             mult_div_reg;
  clock_select_pkg::osc_e osc_state_reg;
  clock_select_pkg::osc_e osc_state_next;
  logic                   internal_freq_ready_reg;
  logic [15:0]            xtal_cnt_reg;
  logic                   xtal_vld_reg;
  logic                   susp_wr;
  logic                   wake;
  logic                   uses_int;

  assign wr_fire = aw_got_reg && w_got_reg && !AXI_BVALID_OUT;
  assign wr_ok = (aw_idx_reg == `CSEL_IDX) || (aw_idx_reg == `ICTL_IDX) ||
                 (aw_idx_reg == `CRS_IDX) || (aw_idx_reg == `FIN_IDX) ||
                 (aw_idx_reg == `XCTL_IDX) || (aw_idx_reg == `MCTL_IDX);

  // Write address and data are taken independently, in either order
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      aw_got_reg <= 1'b0;
      AXI_AWREADY_OUT <= 1'b0;
      aw_idx_reg <= 8'h00;
    end else if (wr_fire) begin
      aw_got_reg <= 1'b0;
      AXI_AWREADY_OUT <= 1'b1;
    end else if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
      aw_got_reg <= 1'b1;
      AXI_AWREADY_OUT <= 1'b0;
      aw_idx_reg <= AXI_AWADDR_IN[9:2];
    end else if (!aw_got_reg) begin
      AXI_AWREADY_OUT <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      w_got_reg <= 1'b0;
      AXI_WREADY_OUT <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
    end else if (wr_fire) begin
      w_got_reg <= 1'b0;
      AXI_WREADY_OUT <= 1'b1;
    end else if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
      w_got_reg <= 1'b1;
      AXI_WREADY_OUT <= 1'b0;
      wdata_reg <= AXI_WDATA_IN[7:0];
      wstrb0_reg <= AXI_WSTRB_IN[0];
    end else if (!w_got_reg) begin
      AXI_WREADY_OUT <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      AXI_BVALID_OUT <= 1'b0;
      AXI_BRESP_OUT <= `RESP_OKAY;
    end else if (wr_fire) begin
      AXI_BVALID_OUT <= 1'b1;
      AXI_BRESP_OUT <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (AXI_BREADY_IN) begin
      AXI_BVALID_OUT <= 1'b0;
    end
  end

  // Only byte lane 0 carries register data; other lanes are ignored
  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_fire && wstrb0_reg && (aw_idx_reg == idx);
  endfunction : wr_hit

  // Reserved source code 11 is refused so the clock never loses its source
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      sel_reg <= clock_select_pkg::SRC_INT;
    end else if (wr_hit(`CSEL_IDX) && wdata_reg[1:0] != 2'h3) begin
      sel_reg <= clock_select_pkg::src_e'(wdata_reg[1:0]);
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      osc_en_reg <= `IEN_RST;
      div_reg <= `IDIV_RST;
    end else if (wr_hit(`ICTL_IDX)) begin
      osc_en_reg <= wdata_reg[`ICTL_EN_HI:`ICTL_EN_LO];
      div_reg <= wdata_reg[2:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      crs_reg <= `CRS_CAL;
      fin_reg <= `FIN_CAL;
    end else begin
      if (wr_hit(`CRS_IDX)) begin
        crs_reg <= wdata_reg[6:0];
      end
      if (wr_hit(`FIN_IDX)) begin
        fin_reg <= wdata_reg[5:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      ext_en_reg <= 1'b0;
      mult_ext_reg <= 1'b0;
      mult_x4_reg <= 1'b0;
      mult_div_reg <= `MDIV_RST;
    end else begin
      if (wr_hit(`XCTL_IDX)) begin
        ext_en_reg <= wdata_reg[`XCTL_EN_BIT];
      end
      if (wr_hit(`MCTL_IDX)) begin
        mult_ext_reg <= wdata_reg[`MCTL_SRC_BIT];
        mult_x4_reg <= wdata_reg[`MCTL_X4_BIT];
        mult_div_reg <= wdata_reg[`MCTL_DIV_HI:`MCTL_DIV_LO];
      end
    end
  end

  // Suspend only takes hold when the same write keeps the oscillator enabled
  assign susp_wr = wr_hit(`ICTL_IDX) && wdata_reg[`ICTL_SUSP_BIT] &&
                   (wdata_reg[`ICTL_EN_HI:`ICTL_EN_LO] == `IEN_RUN);
  assign wake = (|PORT_MATCH_IN) || (CMP0_EN_IN && !CMP0_OUT_IN);

  always_comb begin
    osc_state_next = osc_state_reg;
    case (osc_state_reg)
      clock_select_pkg::OSC_OFF: begin
        if (osc_en_reg == `IEN_RUN) begin
          osc_state_next = clock_select_pkg::OSC_RUN;
        end
      end
      clock_select_pkg::OSC_RUN: begin
        if (osc_en_reg != `IEN_RUN) begin
          osc_state_next = clock_select_pkg::OSC_OFF;
        end else if (susp_wr) begin
          osc_state_next = clock_select_pkg::OSC_SUSP;
        end
      end
      clock_select_pkg::OSC_SUSP: begin
        if (osc_en_reg != `IEN_RUN) begin
          osc_state_next = clock_select_pkg::OSC_OFF;
        end else if (wake) begin
          osc_state_next = clock_select_pkg::OSC_RUN;
        end
      end
      default: osc_state_next = clock_select_pkg::OSC_OFF;
    endcase
  end

  assign uses_int = (sel_reg == clock_select_pkg::SRC_INT) ||
                    (sel_reg == clock_select_pkg::SRC_MULT && !mult_ext_reg);

  // Stall is a hold, not a reset, so the core picks up where it stopped
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      osc_state_reg <= clock_select_pkg::OSC_RUN;
      INT_OSC_RUN_OUT <= 1'b1;
      CORE_STALL_OUT <= 1'b0;
    end else begin
      osc_state_reg <= osc_state_next;
      INT_OSC_RUN_OUT <= (osc_state_next == clock_select_pkg::OSC_RUN);
      CORE_STALL_OUT <= (osc_state_next == clock_select_pkg::OSC_SUSP) && uses_int;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      internal_freq_ready_reg <= 1'b0;
    end else if (osc_state_reg != clock_select_pkg::OSC_RUN) begin
      internal_freq_ready_reg <= 1'b0;
    end else if (INT_OSC_TICK_IN) begin
      internal_freq_ready_reg <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      xtal_cnt_reg <= 16'h0000;
      xtal_vld_reg <= 1'b0;
    end else if (!ext_en_reg) begin
      xtal_cnt_reg <= 16'h0000;
      xtal_vld_reg <= 1'b0;
    end else if (EXT_OSC_TICK_IN && !xtal_vld_reg) begin
      xtal_cnt_reg <= xtal_cnt_reg + 16'h0001;
      if (xtal_cnt_reg == `XTAL_SETTLE_TICKS - 16'h0001) begin
        xtal_vld_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      TIMER_EXT_TICK_OUT <= 1'b0;
    end else begin
      TIMER_EXT_TICK_OUT <= ext_en_reg && EXT_OSC_TICK_IN;
    end
  end

  assign ar_idx = AXI_ARADDR_IN[9:2];
  always_comb begin
    rd_ok = 1'b1;
    case (ar_idx)
      `CSEL_IDX: rd_word = {30'h0, sel_reg};
      `ICTL_IDX: rd_word = {24'h0, osc_en_reg, osc_state_reg == clock_select_pkg::OSC_SUSP,
                            internal_freq_ready_reg, 1'b0, div_reg};
      `CRS_IDX:  rd_word = {25'h0, crs_reg};
      `FIN_IDX:  rd_word = {26'h0, fin_reg};
      `XCTL_IDX: rd_word = {24'h0, xtal_vld_reg, 6'h00, ext_en_reg};
      `MCTL_IDX: rd_word = {25'h0, mult_div_reg, 2'h0, mult_x4_reg, mult_ext_reg};
      default: begin
        rd_word = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (!RST_N_IN) begin
      AXI_ARREADY_OUT <= 1'b0;
      AXI_RVALID_OUT <= 1'b0;
      AXI_RDATA_OUT <= 32'h0000_0000;
      AXI_RRESP_OUT <= `RESP_OKAY;
    end else if (AXI_RVALID_OUT) begin
      if (AXI_RREADY_IN) begin
        AXI_RVALID_OUT <= 1'b0;
        AXI_ARREADY_OUT <= 1'b1;
      end
    end else if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
      AXI_RVALID_OUT <= 1'b1;
      AXI_ARREADY_OUT <= 1'b0;
      AXI_RDATA_OUT <= rd_word;
      AXI_RRESP_OUT <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else begin
      AXI_ARREADY_OUT <= 1'b1;
    end
  end

  // Oscillator ticks are dropped while it is halted
  assign tk.int_tick = INT_OSC_TICK_IN && (osc_state_reg == clock_select_pkg::OSC_RUN);
  assign tk.ext_tick = EXT_OSC_TICK_IN && ext_en_reg;
  assign tk.src = sel_reg;
  assign tk.div_sel = div_reg;
  assign tk.mult_ext = mult_ext_reg;
  assign tk.mult_x4 = mult_x4_reg;
  assign tk.mult_div = mult_div_reg;
  assign SYS_TICK_OUT = tk.sys_tick;
  assign EXT_OSC_EN_OUT = ext_en_reg;
  assign COARSE_TRIM_OUT = crs_reg;
  assign FINE_TRIM_OUT = fin_reg;

  clock_tick_gen u_gen (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (RST_N_IN),
    .t        (tk.gen)
  );

  a_csel_upper_zero: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    AXI_ARVALID_IN && AXI_ARREADY_OUT && ar_idx == `CSEL_IDX
      |=> AXI_RVALID_OUT && AXI_RDATA_OUT[31:2] == 30'h0)
    else $error("clock select upper bits not zero");
  a_reset_defaults: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    $past(RST_N_IN) == 1'b0 |-> sel_reg == clock_select_pkg::SRC_INT && div_reg == 3'h0
      && osc_state_reg == clock_select_pkg::OSC_RUN)
    else $error("reset defaults wrong");
  a_suspend_stall: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    susp_wr && osc_state_reg == clock_select_pkg::OSC_RUN && osc_en_reg == `IEN_RUN
      && uses_int && !wake |=> CORE_STALL_OUT && !INT_OSC_RUN_OUT)
    else $error("suspend did not stall core");
  a_wake_resume: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    osc_state_reg == clock_select_pkg::OSC_SUSP && wake && osc_en_reg == `IEN_RUN
      |=> osc_state_reg == clock_select_pkg::OSC_RUN && !CORE_STALL_OUT && INT_OSC_RUN_OUT)
    else $error("wake did not resume");
  a_suspend_holds: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    osc_state_reg == clock_select_pkg::OSC_SUSP && !wake && osc_en_reg == `IEN_RUN
      |=> osc_state_reg == clock_select_pkg::OSC_SUSP)
    else $error("left suspend without wake");
  a_xtal_settle: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    $rose(xtal_vld_reg) |-> ext_en_reg && xtal_cnt_reg == `XTAL_SETTLE_TICKS)
    else $error("crystal valid before settle count");
  a_osc_disable: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    osc_en_reg != `IEN_RUN |=> osc_state_reg == clock_select_pkg::OSC_OFF ##1 !internal_freq_ready_reg)
    else $error("oscillator not disabled");
  a_internal_freq_ready_running: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    internal_freq_ready_reg |-> $past(osc_state_reg) == clock_select_pkg::OSC_RUN)
    else $error("frequency ready while stopped");
  a_ext_timer: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    ext_en_reg && EXT_OSC_TICK_IN |=> TIMER_EXT_TICK_OUT)
    else $error("external tick lost for timers");
  a_write_resp: assert property (@(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    wr_fire |=> AXI_BVALID_OUT && AXI_BRESP_OUT == (wr_ok ? `RESP_OKAY : `RESP_SLVERR))
    else $error("write response missing");
endmodule : clock_select_top

// ==== testbench/system_clock_select_suspend_tb_top.sv ====
`timescale 1ns/1ps
`include "clock_select_defines.svh"
module system_clock_select_suspend_tb_top;
  logic        clk;
  logic        rst_n;
  logic        int_tick;
  logic        ext_tick;
  logic [3:0]  pmatch;
  logic        cmp_en;
  logic        cmp_out;
  logic [9:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [9:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        sys_tick;
  logic        tmr_tick;
  logic        stall;
  logic        int_run;
  logic        ext_en;
  logic [6:0]  coarse;
  logic [5:0]  fine;
  int          miscompares;
  int          check_count;
  int          cyc;
  int          last_t;
  int          gap;
  int          min_gap;
  int          nsys;
  int          int_per;
  int          ext_per;
  int          iph;
  int          eph;
  logic [31:0] d;
  logic [1:0]  rs;

  clock_select_top dut_u (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .INT_OSC_TICK_IN(int_tick),
    .EXT_OSC_TICK_IN(ext_tick), .PORT_MATCH_IN(pmatch), .CMP0_EN_IN(cmp_en),
    .CMP0_OUT_IN(cmp_out), .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
    .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb),
    .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
    .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready), .AXI_ARADDR_IN(araddr),
    .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata),
    .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready),
    .SYS_TICK_OUT(sys_tick), .TIMER_EXT_TICK_OUT(tmr_tick), .CORE_STALL_OUT(stall),
    .INT_OSC_RUN_OUT(int_run), .EXT_OSC_EN_OUT(ext_en), .COARSE_TRIM_OUT(coarse),
    .FINE_TRIM_OUT(fine));

  always #2.5 clk = ~clk;

  // Oscillator models drop their ticks while their run or enable output is off; the phase counters keep running
  always @(posedge clk) begin
    cyc <= cyc + 1;
    iph <= (iph + 1 >= int_per) ? 0 : iph + 1;
    eph <= (eph + 1 >= ext_per) ? 0 : eph + 1;
    int_tick <= (iph == 0) && (int_run === 1'b1);
    ext_tick <= (eph == 0) && (ext_en === 1'b1);
    if (sys_tick === 1'b1) begin
      gap <= cyc - last_t;
      last_t <= cyc;
      nsys <= nsys + 1;
      if (cyc - last_t < min_gap) min_gap <= cyc - last_t;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_near(input int got, input int exp);
    check_count++;
    if (got > exp + 2 || got < exp - 2) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_near

  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] v, input logic [3:0] st,
                        output logic [1:0] r);
    logic a;
    logic w;
    int   n;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= {24'h000000, v};
    wstrb <= st;
    wvalid <= 1'b1;
    bready <= 1'b1;
    a = 1'b0;
    w = 1'b0;
    n = 0;
    // Each channel is released at the edge that takes it, not before
    while (!(a && w)) begin
      @(posedge clk);
      if (!a && awready === 1'b1) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
      n++;
    end
    a = 1'b0;
    while (!a) begin
      @(posedge clk);
      a = (bvalid === 1'b1);
      r = bresp;
      n++;
    end
    bready <= 1'b0;
    chk({31'h0, n < 200}, 32'h1);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] r);
    logic a;
    int   n;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    a = 1'b0;
    n = 0;
    while (!a) begin
      @(posedge clk);
      a = (arready === 1'b1);
      n++;
    end
    arvalid <= 1'b0;
    a = 1'b0;
    while (!a) begin
      @(posedge clk);
      a = (rvalid === 1'b1);
      v = rdata;
      r = rresp;
      n++;
    end
    rready <= 1'b0;
    chk({31'h0, n < 200}, 32'h1);
  endtask : axi_rd

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    axi_wr(idx, v, 4'hF, rs);
    chk({30'h0, rs}, {30'h0, `RESP_OKAY});
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
    axi_rd(idx, d, rs);
    chk(d & m, e);
    chk({30'h0, rs}, {30'h0, `RESP_OKAY});
  endtask : rd_chk

  task automatic wait_ticks(input int k);
    int s;
    int n;
    s = nsys;
    n = 0;
    while (nsys < s + k && n < 5000) begin
      @(posedge clk);
      n++;
    end
    #1;
    chk({31'h0, n < 5000}, 32'h1);
  endtask : wait_ticks

  task automatic t_reset;
    rd_chk(`CSEL_IDX, 32'hFFFFFFFF, 32'h0);
    rd_chk(`ICTL_IDX, 32'hFFFFFFEF, 32'hC0);
    rd_chk(`CRS_IDX, 32'hFFFFFFFF, {25'h0, `CRS_CAL});
    rd_chk(`FIN_IDX, 32'hFFFFFFFF, {26'h0, `FIN_CAL});
    chk({26'h0, fine}, {26'h0, `FIN_CAL});
    chk({31'h0, int_run}, 32'h1);
    wait_ticks(3);
    chk(gap, 128 * int_per);
    $display("test reset done");
  endtask : t_reset

  task automatic t_select_field;
    wr(`CSEL_IDX, 8'hFC);
    rd_chk(`CSEL_IDX, 32'hFFFFFFFF, 32'h0);
    wr(`CSEL_IDX, 8'hFF);
    rd_chk(`CSEL_IDX, 32'hFFFFFFFF, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(`ICTL_IDX, 8'hC0 | 8'(c));
      wait_ticks(3);
      chk(gap, (128 >> c) * int_per);
    end
    $display("test select and divider done");
  endtask : t_select_field

  task automatic t_crystal;
    chk({31'h0, ext_en}, 32'h0);
    wr(`XCTL_IDX, 8'h01);
    repeat (3850) @(posedge clk);
    rd_chk(`XCTL_IDX, 32'h80, 32'h0);
    repeat (400) @(posedge clk);
    rd_chk(`XCTL_IDX, 32'h80, 32'h80);
    @(posedge clk iff (ext_tick === 1'b1));
    #1;
    chk({31'h0, tmr_tick}, 32'h1);
    min_gap = 1000;
    wr(`CSEL_IDX, 8'hFD);
    rd_chk(`CSEL_IDX, 32'hFFFFFFFF, 32'h1);
    wait_ticks(3);
    chk(gap, ext_per);
    wr(`CSEL_IDX, 8'h00);
    wait_ticks(3);
    chk(gap, int_per);
    chk({31'h0, min_gap >= int_per}, 32'h1);
    $display("test crystal and switch done");
  endtask : t_crystal

  task automatic t_mult;
    int nv[6]  = '{2, 3, 2, 7, 5, 6};
    bit x4v[6] = '{0, 0, 1, 1, 0, 1};
    bit exv[6] = '{0, 0, 0, 0, 1, 1};
    int s;
    int_per = 8;
    ext_per = 8;
    for (int i = 0; i < 6; i++) begin
      wr(`MCTL_IDX, {1'b0, 3'(nv[i]), 2'b00, x4v[i], exv[i]});
      wr(`CSEL_IDX, 8'h02);
      repeat (16) @(posedge clk);
      s = nsys;
      repeat (480) @(posedge clk);
      chk_near(nsys - s, (60 * (x4v[i] ? 8 : 4)) / nv[i]);
    end
    wr(`CSEL_IDX, 8'h00);
    $display("test multiplier done");
  endtask : t_mult

  task automatic t_suspend;
    int s;
    for (int k = 0; k < 5; k++) begin
      wr(`ICTL_IDX, 8'hE7);
      chk({30'h0, stall, int_run}, 32'h2);
      rd_chk(`ICTL_IDX, 32'h30, 32'h20);
      s = nsys;
      cmp_en <= 1'b1;
      repeat (20) @(posedge clk);
      chk(nsys, s);
      chk({31'h0, stall}, 32'h1);
      if (k < 4) pmatch <= 4'(1 << k);
      else cmp_out <= 1'b0;
      @(posedge clk);
      pmatch <= 4'h0;
      cmp_out <= 1'b1;
      cmp_en <= 1'b0;
      #1;
      chk({30'h0, stall, int_run}, 32'h1);
      wait_ticks(2);
      chk(nsys - s >= 2, 32'h1);
    end
    $display("test suspend done");
  endtask : t_suspend

  task automatic t_enable;
    wr(`ICTL_IDX, 8'h07);
    // Run flag follows the enable one edge after the write lands
    #1;
    chk({31'h0, int_run}, 32'h0);
    rd_chk(`ICTL_IDX, 32'h30, 32'h0);
    wr(`ICTL_IDX, 8'hC7);
    #1;
    chk({31'h0, int_run}, 32'h1);
    repeat (20) @(posedge clk);
    rd_chk(`ICTL_IDX, 32'h10, 32'h10);
    $display("test enable done");
  endtask : t_enable

  task automatic t_errors;
    axi_wr(8'h10, 8'h55, 4'hF, rs);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    axi_rd(8'h10, d, rs);
    chk({30'h0, rs}, {30'h0, `RESP_SLVERR});
    axi_wr(`CRS_IDX, 8'h11, 4'hE, rs);
    rd_chk(`CRS_IDX, 32'hFFFFFFFF, {25'h0, `CRS_CAL});
    wr(`CRS_IDX, 8'h95);
    rd_chk(`CRS_IDX, 32'hFFFFFFFF, 32'h15);
    chk({25'h0, coarse}, 32'h15);
    $display("test errors done");
  endtask : t_errors

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    int_tick = 1'b0;
    ext_tick = 1'b0;
    pmatch = 4'h0;
    cmp_en = 1'b0;
    cmp_out = 1'b1;
    awaddr = 10'h000;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 10'h000;
    arvalid = 1'b0;
    rready = 1'b0;
    miscompares = 0;
    check_count = 0;
    cyc = 0;
    last_t = 0;
    gap = 0;
    min_gap = 1000;
    nsys = 0;
    int_per = 2;
    ext_per = 4;
    iph = 0;
    eph = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_select_field;
    t_crystal;
    t_mult;
    t_suspend;
    t_enable;
    t_errors;
    wrap_up;
  end

  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
endmodule : system_clock_select_suspend_tb_top
